// ---- src/mdpp_host.sv ----
// host controller that drives the multiplying dac parallel port pins
`timescale 1ns/100ps
`include "mdpp_defs.svh"

module mdpp_host
	import mdpp_pkg::*;
#(
	parameter int CODE_W = `MDPP_CODE_W
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// software register port
	input wire logic [`MDPP_ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// converter pins
	input wire logic [`MDPP_CODE_W-1:0] code_pins_i,
	input wire logic [`MDPP_SPAN_W-1:0] range_code_pins_i,
	input wire logic fixed_range_strap_i,
	output mdpp_pins_t pins_o
);

	localparam logic [`MDPP_CODE_W-1:0] CODE_MASK = `MDPP_CODE_W'((33'h1 << CODE_W) - 33'h1);

	localparam mdpp_pins_t PINS_RST = '{
		code_pins_o: '0,
		code_pins_oe: 1'b0,
		range_code_pins_o: '0,
		range_code_pins_oe: 1'b0,
		data_span_select: 1'b0,
		store_strobe_n: 1'b1,
		commit_pulse: 1'b0,
		read_line: 1'b0,
		async_zero_n: 1'b1
	};

	localparam mdpp_host_st_t ST_RST = '{
		st: MDPP_IDLE,
		cnt: 4'h0,
		op: 4'h0,
		data: `MDPP_DATA_RST,
		span: `MDPP_SPAN_RST,
		rdback: '0,
		refused: 1'b0,
		rdata: 32'h0000_0000,
		pins: PINS_RST
	};

	function automatic logic [3:0] ld(input int cyc);
		return 4'(cyc - 1);
	endfunction

	mdpp_host_st_t q_r;
	mdpp_host_st_t q_nxt;
	logic [`MDPP_CODE_W-1:0] code_s;
	logic [`MDPP_SPAN_W-1:0] span_s;
	logic strap_s;
	logic cmd_wr;
	logic [3:0] cmd;
	logic span_op;
	logic done;

	mdpp_sync #(.W(`MDPP_CODE_W)) u_sync_code (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(code_pins_i),
		.sync_o(code_s)
	);

	mdpp_sync #(.W(`MDPP_SPAN_W)) u_sync_span (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(range_code_pins_i),
		.sync_o(span_s)
	);

	mdpp_sync #(.W(1)) u_sync_strap (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(fixed_range_strap_i),
		.sync_o(strap_s)
	);

	assign cmd_wr = wr_i && (addr_i == `MDPP_ADDR_CMD);
	assign cmd = wdata_i[3:0];
	assign span_op = (cmd == `MDPP_OP_WR_SPAN) || (cmd == `MDPP_OP_RD_SPAN_IN) ||
		(cmd == `MDPP_OP_RD_SPAN_DAC);
	assign done = (q_r.cnt == 4'h0);

	always_comb begin
		q_nxt = q_r;
		q_nxt.rdata = 32'h0000_0000;
		q_nxt.cnt = done ? 4'h0 : q_r.cnt - 4'h1;
		// a fixed-range part never sees span select or span drive
		q_nxt.pins.data_span_select = q_r.pins.data_span_select & ~strap_s;
		q_nxt.pins.range_code_pins_oe = q_r.pins.range_code_pins_oe & ~strap_s;

		// register writes
		if (wr_i && addr_i == `MDPP_ADDR_DATA) begin
			q_nxt.data = wdata_i[`MDPP_CODE_W-1:0] & CODE_MASK;
		end else if (wr_i && addr_i == `MDPP_ADDR_SPAN) begin
			q_nxt.span = wdata_i[`MDPP_SPAN_W-1:0];
		end else if (wr_i && addr_i == `MDPP_ADDR_STATUS && wdata_i[`MDPP_ST_REFUSED]) begin
			q_nxt.refused = 1'b0;
		end

		// register reads, answered next cycle
		if (rd_i && addr_i == `MDPP_ADDR_DATA) begin
			q_nxt.rdata = 32'(q_r.data);
		end else if (rd_i && addr_i == `MDPP_ADDR_SPAN) begin
			q_nxt.rdata = 32'(q_r.span);
		end else if (rd_i && addr_i == `MDPP_ADDR_STATUS) begin
			q_nxt.rdata[`MDPP_ST_BUSY] = (q_r.st != MDPP_IDLE);
			q_nxt.rdata[`MDPP_ST_FIXED] = strap_s;
			q_nxt.rdata[`MDPP_ST_REFUSED] = q_r.refused;
		end else if (rd_i && addr_i == `MDPP_ADDR_RDBACK) begin
			q_nxt.rdata = 32'(q_r.rdback);
		end

		case (q_r.st)
			MDPP_IDLE: begin
				if (cmd_wr) begin
					q_nxt.op = cmd;
					if (span_op && strap_s) begin
						// span access does not exist on a fixed-range part
						q_nxt.refused = 1'b1;
					end else if (cmd == `MDPP_OP_WR_DATA || cmd == `MDPP_OP_WR_SPAN) begin
						q_nxt.pins.data_span_select = (cmd == `MDPP_OP_WR_SPAN);
						q_nxt.pins.code_pins_o = q_r.data;
						q_nxt.pins.code_pins_oe = (cmd == `MDPP_OP_WR_DATA);
						q_nxt.pins.range_code_pins_o = q_r.span;
						q_nxt.pins.range_code_pins_oe = (cmd == `MDPP_OP_WR_SPAN);
						q_nxt.cnt = ld(`MDPP_SETUP_CYC);
						q_nxt.st = MDPP_W_SETUP;
					end else if (cmd == `MDPP_OP_COMMIT) begin
						// one commit carries data and span, select is left alone
						q_nxt.pins.commit_pulse = 1'b1;
						q_nxt.cnt = ld(`MDPP_PULSE_CYC);
						q_nxt.st = MDPP_U_HIGH;
					end else if (cmd[`MDPP_OP_RD_BIT] && cmd[3] == 1'b0) begin
						q_nxt.pins.data_span_select = cmd[`MDPP_OP_SPAN_BIT];
						q_nxt.cnt = ld(`MDPP_SETUP_CYC);
						q_nxt.st = MDPP_R_SETUP;
					end else if (cmd == `MDPP_OP_CLEAR) begin
						q_nxt.pins.async_zero_n = 1'b0;
						q_nxt.cnt = ld(`MDPP_CLR_CYC);
						q_nxt.st = MDPP_C_LOW;
					end else begin
						q_nxt.refused = 1'b1;
					end
				end
			end
			MDPP_W_SETUP: begin
				if (done) begin
					q_nxt.pins.store_strobe_n = 1'b0;
					q_nxt.cnt = ld(`MDPP_PULSE_CYC);
					q_nxt.st = MDPP_W_LOW;
				end
			end
			MDPP_W_LOW: begin
				if (done) begin
					q_nxt.pins.store_strobe_n = 1'b1;
					q_nxt.cnt = ld(`MDPP_HOLD_CYC);
					q_nxt.st = MDPP_W_HOLD;
				end
			end
			MDPP_W_HOLD: begin
				if (done) begin
					q_nxt.pins.code_pins_oe = 1'b0;
					q_nxt.pins.range_code_pins_oe = 1'b0;
					q_nxt.pins.data_span_select = 1'b0;
					q_nxt.st = MDPP_IDLE;
				end
			end
			MDPP_U_HIGH: begin
				if (done) begin
					q_nxt.pins.commit_pulse = 1'b0;
					q_nxt.st = MDPP_IDLE;
				end
			end
			MDPP_R_SETUP: begin
				if (done) begin
					// bus is already released before read rises
					q_nxt.pins.read_line = 1'b1;
					q_nxt.cnt = ld(`MDPP_SEL_CYC);
					q_nxt.st = MDPP_R_SEL;
				end
			end
			MDPP_R_SEL: begin
				if (done) begin
					q_nxt.pins.commit_pulse = q_r.op[`MDPP_OP_DAC_BIT];
					q_nxt.cnt = ld(`MDPP_PROP_CYC);
					q_nxt.st = MDPP_R_WAIT;
				end
			end
			MDPP_R_WAIT: begin
				if (done) begin
					q_nxt.rdback = q_r.op[`MDPP_OP_SPAN_BIT] ?
						`MDPP_CODE_W'(span_s) : (code_s & CODE_MASK);
					q_nxt.pins.commit_pulse = 1'b0;
					q_nxt.cnt = ld(`MDPP_SEL_CYC);
					q_nxt.st = MDPP_R_DESEL;
				end
			end
			MDPP_R_DESEL: begin
				if (done) begin
					q_nxt.pins.read_line = 1'b0;
					q_nxt.cnt = ld(`MDPP_TURN_CYC);
					q_nxt.st = MDPP_R_TURN;
				end
			end
			MDPP_R_TURN: begin
				// no drive and no new command until the device lets go
				if (done) begin
					q_nxt.pins.data_span_select = 1'b0;
					q_nxt.st = MDPP_IDLE;
				end
			end
			MDPP_C_LOW: begin
				if (done) begin
					q_nxt.pins.async_zero_n = 1'b1;
					q_nxt.st = MDPP_IDLE;
				end
			end
			default: begin
				q_nxt.st = MDPP_IDLE;
			end
		endcase

		// commands arriving while busy are dropped, flagged sticky
		if (cmd_wr && q_r.st != MDPP_IDLE) begin
			q_nxt.refused = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			q_r <= ST_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign rdata_o = q_r.rdata;
	assign pins_o = q_r.pins;

	chk_bus_off_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		pins_o.read_line |-> !pins_o.code_pins_oe && !pins_o.range_code_pins_oe)
		else $error("bus driven while read line high");

	chk_turn_wait: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$fell(pins_o.read_line) |-> (!pins_o.code_pins_oe && !pins_o.range_code_pins_oe)[*2])
		else $error("bus driven too soon after read fell");

	chk_fixed_select: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$past(strap_s) |-> !pins_o.data_span_select && !pins_o.range_code_pins_oe)
		else $error("span selected on fixed-range part");

	chk_store_width: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$fell(pins_o.store_strobe_n) |-> !pins_o.store_strobe_n[*2] ##1 pins_o.store_strobe_n)
		else $error("store strobe pulse not two cycles");

	chk_store_setup: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$fell(pins_o.store_strobe_n) |-> $past(pins_o.code_pins_oe ^ pins_o.range_code_pins_oe)
		&& $stable(pins_o.data_span_select) && $stable(pins_o.code_pins_o))
		else $error("store strobe without set-up of one pin group");

	chk_store_no_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		pins_o.read_line |-> pins_o.store_strobe_n)
		else $error("store strobe during read");

	chk_commit_width: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$rose(pins_o.commit_pulse) && !pins_o.read_line |->
		(pins_o.commit_pulse && !pins_o.read_line)[*2] ##1 !pins_o.commit_pulse)
		else $error("commit pulse not two cycles");

	chk_read_source: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$rose(pins_o.commit_pulse) && pins_o.read_line |->
		(pins_o.read_line && pins_o.commit_pulse)[*4] ##1 (pins_o.read_line && !pins_o.commit_pulse))
		else $error("dac source select not framed by read");

	chk_clear_width: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$fell(pins_o.async_zero_n) |-> !pins_o.async_zero_n[*2] ##1 pins_o.async_zero_n)
		else $error("clear pulse not two cycles");

	chk_read_answer: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		rd_i && addr_i == `MDPP_ADDR_RDBACK |=> rdata_o == 32'($past(q_r.rdback)))
		else $error("readback register answer wrong");

endmodule

// ---- src/mdpp_defs.svh ----
// offsets, field positions, reset values and timing counts of the dac pin controller
`ifndef MDPP_DEFS_SVH
`define MDPP_DEFS_SVH

`define MDPP_CODE_W 16
`define MDPP_SPAN_W 3
`define MDPP_ADDR_W 8

// register offsets of the controller
`define MDPP_ADDR_CMD 8'h00
`define MDPP_ADDR_DATA 8'h04
`define MDPP_ADDR_SPAN 8'h08
`define MDPP_ADDR_STATUS 8'h0c
`define MDPP_ADDR_RDBACK 8'h10

// command codes written to the command register
`define MDPP_OP_WR_DATA 4'h1
`define MDPP_OP_WR_SPAN 4'h2
`define MDPP_OP_COMMIT 4'h3
`define MDPP_OP_RD_DATA_IN 4'h4
`define MDPP_OP_RD_DATA_DAC 4'h5
`define MDPP_OP_RD_SPAN_IN 4'h6
`define MDPP_OP_RD_SPAN_DAC 4'h7
`define MDPP_OP_CLEAR 4'h8
`define MDPP_OP_RD_BIT 2
`define MDPP_OP_SPAN_BIT 1
`define MDPP_OP_DAC_BIT 0

// status bit positions
`define MDPP_ST_BUSY 0
`define MDPP_ST_FIXED 1
`define MDPP_ST_REFUSED 2

// reset values
`define MDPP_DATA_RST 16'h0000
`define MDPP_SPAN_RST 3'h0

// timing, nanoseconds as printed, then whole clock cycles rounded up
`define MDPP_CLK_NS 20
`define MDPP_CYC(ns) ((((ns) + `MDPP_CLK_NS - 1) / `MDPP_CLK_NS) < 1 ? 1 : \
	(((ns) + `MDPP_CLK_NS - 1) / `MDPP_CLK_NS))
`define MDPP_T_SETUP_NS 18
`define MDPP_T_PULSE_NS 30
`define MDPP_T_HOLD_NS 18
`define MDPP_T_SEL_NS 9
`define MDPP_T_PROP_NS 40
`define MDPP_T_TURN_NS 40
`define MDPP_T_CLR_NS 30
`define MDPP_SYNC_CYC 2
`define MDPP_SETUP_CYC `MDPP_CYC(`MDPP_T_SETUP_NS)
`define MDPP_PULSE_CYC `MDPP_CYC(`MDPP_T_PULSE_NS)
`define MDPP_HOLD_CYC `MDPP_CYC(`MDPP_T_HOLD_NS)
`define MDPP_SEL_CYC `MDPP_CYC(`MDPP_T_SEL_NS)
`define MDPP_PROP_CYC (`MDPP_CYC(`MDPP_T_PROP_NS) + `MDPP_SYNC_CYC)
`define MDPP_TURN_CYC `MDPP_CYC(`MDPP_T_TURN_NS)
`define MDPP_CLR_CYC `MDPP_CYC(`MDPP_T_CLR_NS)

`endif

// ---- src/mdpp_pkg.sv ----
// types of the dac pin controller
`include "mdpp_defs.svh"

package mdpp_pkg;

	typedef enum logic [3:0] {
		MDPP_IDLE,
		MDPP_W_SETUP,
		MDPP_W_LOW,
		MDPP_W_HOLD,
		MDPP_U_HIGH,
		MDPP_R_SETUP,
		MDPP_R_SEL,
		MDPP_R_WAIT,
		MDPP_R_DESEL,
		MDPP_R_TURN,
		MDPP_C_LOW
	} mdpp_state_t;

	// every pin the controller drives toward the converter
	typedef struct packed {
		logic [`MDPP_CODE_W-1:0] code_pins_o;
		logic code_pins_oe;
		logic [`MDPP_SPAN_W-1:0] range_code_pins_o;
		logic range_code_pins_oe;
		logic data_span_select;
		logic store_strobe_n;
		logic commit_pulse;
		logic read_line;
		logic async_zero_n;
	} mdpp_pins_t;

	typedef struct packed {
		mdpp_state_t st;
		logic [3:0] cnt;
		logic [3:0] op;
		logic [`MDPP_CODE_W-1:0] data;
		logic [`MDPP_SPAN_W-1:0] span;
		logic [`MDPP_CODE_W-1:0] rdback;
		logic refused;
		logic [31:0] rdata;
		mdpp_pins_t pins;
	} mdpp_host_st_t;

endpackage

// ---- src/mdpp_sync.sv ----
// two-stage synchroniser for pins read from the converter
`timescale 1ns/100ps

module mdpp_sync
	import mdpp_pkg::*;
#(
	parameter int W = 1
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// pins in, synchronised out
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} mdpp_sync_st_t;

	mdpp_sync_st_t q_r;
	mdpp_sync_st_t q_nxt;

	always_comb begin
		q_nxt.s1 = pin_i;
		q_nxt.s2 = q_r.s1;
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign sync_o = q_r.s2;

endmodule

// ---- bench/mdpp_dev_model.sv ----
// behavioural model of the converter's parallel port
`timescale 1ns/100ps

module mdpp_dev_model
	import mdpp_pkg::*;
(
	// sampling clock
	input wire logic core_clk_i,
	// controller pins and strap
	input wire mdpp_pins_t pins_i,
	input wire logic fixed_range_strap_i,
	// resolved bus levels and sticky protocol fault
	output logic [15:0] code_bus_o,
	output logic [2:0] range_bus_o,
	output logic clash_o
);
	logic [15:0] data_in_r, data_dac_r, junk_r;
	logic [2:0] span_in_r, span_dac_r, turn_r;
	logic strobe_q;
	mdpp_pins_t p;
	assign p = pins_i;
	initial begin
		data_in_r = 16'h0;
		data_dac_r = 16'h0;
		span_in_r = 3'h0;
		span_dac_r = 3'h0;
		junk_r = 16'h0;
		turn_r = 3'h3;
		strobe_q = 1'b1;
		clash_o = 1'b0;
	end
	always @(posedge core_clk_i or negedge pins_i.async_zero_n) begin
		if (!pins_i.async_zero_n) begin
			data_in_r <= 16'h0;
			data_dac_r <= 16'h0;
		end else begin
			strobe_q <= p.store_strobe_n;
			if (p.store_strobe_n && !strobe_q && !p.read_line) begin
				if (!p.data_span_select)
					data_in_r <= code_bus_o;
				else if (!fixed_range_strap_i)
					span_in_r <= range_bus_o;
			end
			if (p.commit_pulse && !p.read_line) begin
				data_dac_r <= data_in_r;
				if (!fixed_range_strap_i)
					span_dac_r <= span_in_r;
			end
		end
	end
	// released lines show a walking pattern, not the last value
	assign code_bus_o = p.code_pins_oe ? p.code_pins_o :
		(p.read_line && !p.data_span_select) ?
		(p.commit_pulse ? data_dac_r : data_in_r) : junk_r;
	assign range_bus_o = p.range_code_pins_oe ? p.range_code_pins_o :
		(p.read_line && p.data_span_select && !fixed_range_strap_i) ?
		(p.commit_pulse ? span_dac_r : span_in_r) : junk_r[2:0];
	always @(posedge core_clk_i) begin
		junk_r <= {junk_r[14:0], ~junk_r[15]};
		turn_r <= (p.read_line !== 1'b0) ? 3'h0 : (turn_r == 3'h3 ? 3'h3 : turn_r + 3'h1);
		if ((p.code_pins_oe || p.range_code_pins_oe) && (p.read_line || turn_r < 3'h2))
			clash_o <= 1'b1;
		if (fixed_range_strap_i && p.data_span_select)
			clash_o <= 1'b1;
	end
endmodule

// ---- bench/tb_mdpp_host.sv ----
// self-checking bench of the dac pin controller
`timescale 1ns/100ps
`include "mdpp_defs.svh"

module tb_mdpp_host
	import mdpp_pkg::*;
;
	logic clk = 0, rst = 1, wr = 0, rd = 0, strap = 0, clash;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [15:0] cbus, d, din, ddac;
	logic [2:0] sbus, s, sin, sdac;
	mdpp_pins_t pins;
	int err_count = 0, total_checks = 0;

	always #10 clk = ~clk;

	mdpp_host dut (.core_clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .code_pins_i(cbus),
		.range_code_pins_i(sbus), .fixed_range_strap_i(strap), .pins_o(pins));
	mdpp_dev_model dev (.core_clk_i(clk), .pins_i(pins), .fixed_range_strap_i(strap),
		.code_bus_o(cbus), .range_bus_o(sbus), .clash_o(clash));

	task check(string n, logic [31:0] sn, logic [31:0] ex);
		total_checks++;
		if (sn !== ex) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, ex, sn);
		end
	endtask
	task wreg(logic [7:0] a, logic [31:0] dt);
		@(posedge clk);
		addr <= a;
		wdata <= dt;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rreg(logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task idle;
		int i;
		for (i = 0; i < 40 && (i == 0 || v[`MDPP_ST_BUSY] !== 1'b0); i++)
			rreg(`MDPP_ADDR_STATUS);
		check("busy", v[`MDPP_ST_BUSY], 1'b0);
	endtask
	task cmd(logic [3:0] op);
		wreg(`MDPP_ADDR_CMD, {28'h0, op});
		idle;
	endtask
	function logic [15:0] exp_rd(logic [3:0] op);
		case (op)
			`MDPP_OP_RD_DATA_IN: exp_rd = din;
			`MDPP_OP_RD_DATA_DAC: exp_rd = ddac;
			`MDPP_OP_RD_SPAN_IN: exp_rd = {13'h0, sin};
			default: exp_rd = {13'h0, sdac};
		endcase
	endfunction
	task rdall;
		logic [3:0] op;
		for (op = `MDPP_OP_RD_DATA_IN; op <= `MDPP_OP_RD_SPAN_DAC; op++) begin
			cmd(op);
			rreg(`MDPP_ADDR_RDBACK);
			check("readback", v, {16'h0, exp_rd(op)});
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#400000;
		err_count++;
		finish_test;
	end

	initial begin
		v = $urandom(32'h1ccaa4b2);
		{din, ddac, sin, sdac} = '0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		rreg(8'h20);
		check("unmapped", v, 32'h0);
		rreg(`MDPP_ADDR_STATUS);
		check("status", v, 32'h0);
		rdall;
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 16'hffff : $urandom;
			s = (i == 0) ? 3'h7 : $urandom;
			wreg(`MDPP_ADDR_DATA, {$urandom, d});
			wreg(`MDPP_ADDR_SPAN, {$urandom, s});
			rreg(`MDPP_ADDR_DATA);
			check("data reg", v, {16'h0, d});
			cmd(`MDPP_OP_WR_DATA);
			din = d;
			rdall;
			cmd(`MDPP_OP_WR_SPAN);
			sin = s;
			cmd(`MDPP_OP_COMMIT);
			ddac = din;
			sdac = sin;
			rdall;
		end
		cmd(`MDPP_OP_CLEAR);
		din = 16'h0;
		ddac = 16'h0;
		rdall;
		wreg(`MDPP_ADDR_CMD, 32'h9);
		rreg(`MDPP_ADDR_STATUS);
		check("refused", v[`MDPP_ST_REFUSED], 1'b1);
		wreg(`MDPP_ADDR_STATUS, 32'h1 << `MDPP_ST_REFUSED);
		rreg(`MDPP_ADDR_STATUS);
		check("refused clr", v[`MDPP_ST_REFUSED], 1'b0);
		d = $urandom;
		wreg(`MDPP_ADDR_DATA, {16'h0, d});
		wreg(`MDPP_ADDR_CMD, {28'h0, `MDPP_OP_WR_DATA});
		wreg(`MDPP_ADDR_CMD, {28'h0, `MDPP_OP_COMMIT});
		idle;
		din = d;
		check("busy refused", v[`MDPP_ST_REFUSED], 1'b1);
		rdall;
		@(posedge clk);
		// the strap only changes under reset, as on a board
		strap <= 1'b1;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		wreg(`MDPP_ADDR_STATUS, 32'h1 << `MDPP_ST_REFUSED);
		rreg(`MDPP_ADDR_STATUS);
		check("strap", v[`MDPP_ST_FIXED], 1'b1);
		cmd(`MDPP_OP_WR_SPAN);
		check("span refused", v[`MDPP_ST_REFUSED], 1'b1);
		wreg(`MDPP_ADDR_STATUS, 32'h1 << `MDPP_ST_REFUSED);
		cmd(`MDPP_OP_RD_SPAN_IN);
		check("span rd refused", v[`MDPP_ST_REFUSED], 1'b1);
		check("span kept", dev.span_in_r, sin);
		check("span oe", pins.range_code_pins_oe, 1'b0);
		check("select", pins.data_span_select, 1'b0);
		d = $urandom;
		wreg(`MDPP_ADDR_DATA, {16'h0, d});
		cmd(`MDPP_OP_WR_DATA);
		cmd(`MDPP_OP_COMMIT);
		cmd(`MDPP_OP_RD_DATA_DAC);
		rreg(`MDPP_ADDR_RDBACK);
		check("fixed data", v, {16'h0, d});
		check("bus fault", clash, 1'b0);
		finish_test;
	end
endmodule
